// ===== pec_defines.svh
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PEC_ADDR_W          8
`define PEC_DATA_W          32
`define PEC_CNT_W           48

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PEC_OFS_EVTSEL      8'h00
`define PEC_OFS_CNT_LO      8'h04
`define PEC_OFS_CNT_HI      8'h08
`define PEC_OFS_STATUS      8'h0c

// ----------------------------------------------------------------
// Event select fields and reset values
// ----------------------------------------------------------------
`define PEC_SEL_CODE_RANGE  7:0
`define PEC_SEL_UMASK_RANGE 15:8
`define PEC_SEL_SPEC_RANGE  15:14
`define PEC_SEL_AGENT_BIT   13
`define PEC_SEL_EN_BIT      22
`define PEC_SEL_RST         32'h0000_0000
`define PEC_CNT_RST         48'h0000_0000_0000
`define PEC_SPEC_ALL        2'b11

// ----------------------------------------------------------------
// Event codes and unit masks
// ----------------------------------------------------------------
`define PEC_EV_L2_REJECT    8'h30
`define PEC_EV_L2_IDLE      8'h32
`define PEC_EV_CYCLES       8'h3c
`define PEC_UM_CORE_CYC     2'h0
`define PEC_UM_REF_CYC      2'h1
`define PEC_UM_SERIAL_CYC   2'h2
`define PEC_EV_PREF_REQ     8'h4f
`define PEC_EV_SHARE_SNOOP  8'h78
`define PEC_EV_BUS_SNOOP    8'h77
`define PEC_EV_BUS_IDLE     8'h7d
`define PEC_EV_BUS_DRDY     8'h62

`endif

// ===== pec_pkg.sv
package pec_pkg;

  // Microarchitectural conditions seen by this core, one cycle each
  typedef struct packed {
    logic coreHalted;
    logic snoopActive;
    logic otherHalted;
    logic busTick;
    logic l2RejThis;
    logic l2RejOther;
    logic l2IdleThis;
    logic l2IdleOther;
    logic prefReqThis;
    logic prefReqOther;
    logic shareSnpThis;
    logic shareSnpOther;
    logic busIdleThis;
    logic busIdleOther;
    logic busSnpThis;
    logic busSnpOther;
    logic drdyThis;
    logic drdyOther;
  } pec_events_t;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  addr;
    logic [31:0] wrData;
  } pec_reg_req_t;

  typedef struct packed {
    logic [7:0]  evCode;
    logic [7:0]  unitMask;
    logic        enable;
    logic [47:0] count;
    logic [31:0] rdData;
  } pec_state_t;

endpackage : pec_pkg

// ===== pec_counter.sv
`timescale 1ns/10ps
`include "pec_defines.svh"
// Functional notes
// - Core counts as active while executing code, not while halted.
// - Core also counts as active while snooped, even when halted.
// - Shared-unit events qualify by processor or bus agent boundary via unit mask.
// - Unit mask top two bits choose this core or either core.
// - All-cores encoding counts the shared condition of every core.
// - Cycle events under code 3C stop on a halted core, snooped or not.
// - Bus data-ready event with all-agents mask counts every bus agent.
// - Second-level reject event counts each reject cycle.
// - Second-level idle-request event counts each cycle without requests.
// - Core cycle event counts every core clock while not halted.
// - Reference cycle event counts bus clock cycles while not halted.
// - Serial execution counts bus cycles running while other core halted.
// - Prefetch request event counts every request, resubmissions again.
// - Share snoop event counts each data cache store-port share snoop, only while unit mask bit 0 is set.
// - Bus-idle event counts bus cycles with nothing outstanding.
// - Bus snoop event counts clean, hit and hit-modified responses.
module pec_counter
  import pec_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clkEn,
  input  wire pec_events_t  events,
  input  wire pec_reg_req_t regReq,
  output logic [31:0]       regRdData
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pec_state_t stateQ;
  pec_state_t stateD;

  logic       coreActive;
  logic       coreRunning;
  logic       allCores;
  logic       allAgents;
  logic [1:0] cycSel;
  logic       incThis;
  logic       incOther;
  logic [1:0] incAmount;
  logic [31:0] selView;
  logic [31:0] statusView;

  // ----------------------------------------------------------------
  // Activity qualification
  // ----------------------------------------------------------------
  // Snoops keep a halted core active so snoop-driven events still count
  assign coreActive  = !events.coreHalted || events.snoopActive;
  // Cycle events must ignore snoop activity
  assign coreRunning = !events.coreHalted;

  // Core-specificity subfield lives in the top of the unit mask
  assign allCores  = (stateQ.unitMask[7:6] == `PEC_SPEC_ALL);
  assign allAgents = stateQ.unitMask[`PEC_SEL_AGENT_BIT - 8];
  assign cycSel    = stateQ.unitMask[1:0];

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  always_comb begin
    incThis  = 1'b0;
    incOther = 1'b0;
    case (stateQ.evCode)
      `PEC_EV_L2_REJECT: begin
        incThis  = events.l2RejThis;
        incOther = allCores && events.l2RejOther;
      end
      `PEC_EV_L2_IDLE: begin
        incThis  = events.l2IdleThis;
        incOther = allCores && events.l2IdleOther;
      end
      `PEC_EV_CYCLES: begin
        case (cycSel)
          `PEC_UM_CORE_CYC: begin
            incThis = coreRunning;
          end
          `PEC_UM_REF_CYC: begin
            incThis = coreRunning && events.busTick;
          end
          `PEC_UM_SERIAL_CYC: begin
            // Needs a bus cycle, this core running and the other halted
            incThis = coreRunning && events.otherHalted && events.busTick;
          end
          default: begin
            incThis = 1'b0;
          end
        endcase
      end
      `PEC_EV_PREF_REQ: begin
        // Resubmitted requests arrive as new pulses and count again
        incThis  = events.prefReqThis;
        incOther = allCores && events.prefReqOther;
      end
      `PEC_EV_SHARE_SNOOP: begin
        incThis = stateQ.unitMask[0] && events.shareSnpThis;
        incOther = stateQ.unitMask[0] && allCores && events.shareSnpOther;
      end
      `PEC_EV_BUS_SNOOP: begin
        incThis  = events.busSnpThis;
        incOther = allAgents && events.busSnpOther;
      end
      `PEC_EV_BUS_IDLE: begin
        incThis  = events.busIdleThis && events.busTick;
        incOther = allAgents && events.busIdleOther && events.busTick;
      end
      `PEC_EV_BUS_DRDY: begin
        incThis  = events.drdyThis;
        incOther = (allAgents || allCores) && events.drdyOther;
      end
      default: begin
        incThis  = 1'b0;
        incOther = 1'b0;
      end
    endcase
  end

  // Nothing counts outside active periods or while disabled
  always_comb begin
    incAmount = 2'h0;
    if (stateQ.enable && coreActive) begin
      incAmount = {1'b0, incThis} + {1'b0, incOther};
    end
  end

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  always_comb begin
    selView = 32'h0000_0000;
    selView[`PEC_SEL_CODE_RANGE]  = stateQ.evCode;
    selView[`PEC_SEL_UMASK_RANGE] = stateQ.unitMask;
    selView[`PEC_SEL_EN_BIT]      = stateQ.enable;
  end

  always_comb begin
    statusView    = 32'h0000_0000;
    statusView[0] = coreActive;
    statusView[1] = events.coreHalted;
    statusView[2] = events.snoopActive;
    statusView[3] = stateQ.enable;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    // Read data stands only in the cycle after the strobe
    stateD.rdData = 32'h0000_0000;
    // Software load of the count takes priority over an increment
    stateD.count = stateQ.count + {46'h0, incAmount};
    if (regReq.wrEn) begin
      case (regReq.addr)
        `PEC_OFS_EVTSEL: begin
          stateD.evCode   = regReq.wrData[`PEC_SEL_CODE_RANGE];
          stateD.unitMask = regReq.wrData[`PEC_SEL_UMASK_RANGE];
          stateD.enable   = regReq.wrData[`PEC_SEL_EN_BIT];
        end
        `PEC_OFS_CNT_LO: begin
          stateD.count[31:0] = regReq.wrData;
        end
        `PEC_OFS_CNT_HI: begin
          stateD.count[47:32] = regReq.wrData[15:0];
        end
        default: begin
          stateD.rdData = 32'h0000_0000;
        end
      endcase
    end
    if (regReq.rdEn) begin
      case (regReq.addr)
        `PEC_OFS_EVTSEL: begin
          stateD.rdData = selView;
        end
        `PEC_OFS_CNT_LO: begin
          stateD.rdData = stateQ.count[31:0];
        end
        `PEC_OFS_CNT_HI: begin
          stateD.rdData = {16'h0000, stateQ.count[47:32]};
        end
        `PEC_OFS_STATUS: begin
          stateD.rdData = statusView;
        end
        default: begin
          stateD.rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stateQ.evCode   <= 8'h00;
      stateQ.unitMask <= 8'h00;
      stateQ.enable   <= 1'b0;
      stateQ.count    <= `PEC_CNT_RST;
      stateQ.rdData   <= 32'h0000_0000;
    end else if (clkEn) begin
      stateQ <= stateD;
    end
  end

  assign regRdData = stateQ.rdData;

endmodule : pec_counter

// ===== pec_counter_assertions.sv
`timescale 1ns/10ps
module pec_counter_checker import pec_pkg::*; (
  input wire logic         clock,
  input wire logic         sys_rst,
  input wire logic         clkEn,
  input wire pec_events_t  events,
  input wire pec_reg_req_t regReq,
  input wire logic [31:0]  regRdData
);
  // ----------------------------------------------------------------
  // Shadow of the selection register
  // ----------------------------------------------------------------
  logic [31:0] selQ;
  wire         rd  = clkEn && regReq.rdEn;
  wire         act = !events.coreHalted || events.snoopActive;
  wire [1:0]   hs  = {events.snoopActive, events.coreHalted};
  wire         en  = selQ[22];

  always_ff @(posedge clock) begin
    if (sys_rst) selQ <= 32'h0;
    else if (clkEn && regReq.wrEn && regReq.addr == 8'h00)
      selQ <= {9'h0, regReq.wrData[22], 6'h0, regReq.wrData[15:0]};
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_RD_IDLE: assert property (clkEn && !regReq.rdEn |=> regRdData == 32'h0)
    else $error("read data not cleared");
  AST_FREEZE: assert property (!clkEn |=> $stable(regRdData))
    else $error("read data moved while frozen");
  AST_UNMAPPED: assert property (rd && regReq.addr > 8'h0c |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  AST_SEL_BACK: assert property (rd && regReq.addr == 8'h00 |=> regRdData == $past(selQ))
    else $error("selection read-back wrong");
  AST_CNT_HI: assert property (rd && regReq.addr == 8'h08 |=> regRdData[31:16] == 16'h0)
    else $error("count high upper bits set");
  AST_ACTIVE: assert property (rd && regReq.addr == 8'h0c |=> regRdData[0] == $past(act))
    else $error("active status wrong");
  AST_HALT: assert property (rd && regReq.addr == 8'h0c |=> regRdData[2:1] == $past(hs))
    else $error("halt or snoop status wrong");
  AST_EN: assert property (rd && regReq.addr == 8'h0c |=> regRdData[3] == $past(en))
    else $error("enable status wrong");

  cover property (rd && regReq.addr == 8'h04);
  cover property (rd && regReq.addr == 8'h0c);
  cover property (!clkEn && !events.coreHalted);
endmodule : pec_counter_checker

bind pec_counter pec_counter_checker pec_counter_checker_inst (.clock(clock),
  .sys_rst(sys_rst), .clkEn(clkEn), .events(events), .regReq(regReq), .regRdData(regRdData));

// ===== pec_counter_bench.sv
`timescale 1ns/10ps
module pec_counter_bench import pec_pkg::*;;
  // Event bits from MSB: coreHalted snoopActive otherHalted busTick, then
  // l2Rej l2Idle prefReq shareSnp busIdle busSnp drdy, each This then Other
  localparam logic [17:0] HALT = 18'h20000;
  logic         clock      = 1'b0;
  logic         sys_rst    = 1'b1;
  logic         clkEn      = 1'b1;
  pec_events_t  events     = HALT;
  pec_reg_req_t regReq     = '0;
  logic [31:0]  regRdData;
  int           num_errors = 0;
  int           num_checks = 0;
  int           cycles     = 0;

  pec_counter pec_counter_inst (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
    .events(events), .regReq(regReq), .regRdData(regRdData));

  always #5 clock = ~clock;

  // Ceiling well above the roughly 320 cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clock);
    regReq.wrEn <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 32'h0};
    @(posedge clock);
    regReq.rdEn <= 1'b0;
    #1 chk(n, e, regRdData);
    @(posedge clock);
  endtask : rd

  // Events stay halted outside the window, so no selection counts then
  task automatic cnt(input logic [7:0] c, u, input logic [17:0] e, input int n,
                     input logic [31:0] pre, input logic [47:0] x);
    wr(8'h04, pre);
    wr(8'h08, 32'h0);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: 8'h00, wrData: {9'h0, 1'b1, 6'h0, u, c}};
    @(posedge clock);
    regReq.wrEn <= 1'b0;
    events      <= e;
    repeat (n) @(posedge clock);
    events <= HALT;
    rd(8'h04, x[31:0], "count low");
    rd(8'h08, {16'h0, x[47:32]}, "count high");
  endtask : cnt

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_events();
    cnt(8'h30, 8'h00, 18'h02000, 5, 0, 5);
    cnt(8'h32, 8'h00, 18'h00800, 4, 0, 4);
    cnt(8'h4f, 8'h00, 18'h00200, 3, 0, 3);
    cnt(8'h78, 8'h01, 18'h00080, 6, 0, 6);
    cnt(8'h78, 8'h00, 18'h00080, 6, 0, 0);
    cnt(8'h7d, 8'h00, 18'h04020, 5, 0, 5);
    cnt(8'h7d, 8'h00, 18'h00020, 5, 0, 0);
    cnt(8'h77, 8'h00, 18'h0000c, 4, 0, 4);
    $display("test_events done");
  endtask : test_events

  task automatic test_cycles();
    cnt(8'h3c, 8'h00, 18'h00000, 7, 0, 7);
    cnt(8'h3c, 8'h00, 18'h30000, 5, 0, 0);
    cnt(8'h3c, 8'h01, 18'h04000, 3, 0, 3);
    cnt(8'h3c, 8'h02, 18'h0c000, 4, 0, 4);
    cnt(8'h3c, 8'h02, 18'h04000, 4, 0, 0);
    cnt(8'h30, 8'h00, 18'h32000, 3, 0, 3);
    cnt(8'h30, 8'h00, 18'h22000, 3, 0, 0);
    cnt(8'h3c, 8'h00, 18'h00000, 3, 32'hffff_fffe, 48'h1_0000_0001);
    $display("test_cycles done");
  endtask : test_cycles

  task automatic test_shared();
    cnt(8'h77, 8'h20, 18'h0000c, 4, 0, 8);
    cnt(8'h62, 8'h20, 18'h00003, 4, 0, 8);
    cnt(8'h62, 8'h00, 18'h00003, 4, 0, 4);
    cnt(8'h4f, 8'hc0, 18'h00300, 3, 0, 6);
    cnt(8'h4f, 8'h80, 18'h00300, 3, 0, 3);
    cnt(8'h30, 8'h40, 18'h01000, 3, 0, 0);
    $display("test_shared done");
  endtask : test_shared

  task automatic test_regs();
    wr(8'h00, 32'h0040_c03c);
    rd(8'h00, 32'h0040_c03c, "selection");
    rd(8'h0c, 32'h0000_000a, "status");
    rd(8'h10, 32'h0, "unmapped");
    wr(8'h04, 32'h0000_0055);
    events <= 18'h00000;
    clkEn  <= 1'b0;
    repeat (4) @(posedge clock);
    events <= HALT;
    clkEn  <= 1'b1;
    rd(8'h04, 32'h0000_0055, "frozen count");
    $display("test_regs done");
  endtask : test_regs

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(8'h04, 32'h0, "reset count");
    test_events();
    test_cycles();
    test_shared();
    test_regs();
    results();
  end
endmodule : pec_counter_bench
